// ==== rtl/scgc_pkg.sv ====
// Purpose: Shared constants and carriers for the serializer configuration bank
// Assumes: Register port is the internal side of the serial control bus slave
// Notes:   Offsets and fields are byte registers of eight bits
package scgc_pkg;
   localparam int          DATA_W          = 8;
   localparam int          ADDR_W          = 8;
   localparam int          TGT_W           = 7;
   // Register offsets
   localparam logic [7:0]  OFS_SOFT_RESET  = 8'h01;
   localparam logic [7:0]  OFS_GEN_CFG     = 8'h03;
   // Soft reset control fields
   localparam int          RST_KEEP_BIT    = 0;
   localparam int          RST_FULL_BIT    = 1;
   localparam int          RST_PWRDN_BIT   = 7;
   localparam logic [7:0]  RST_CTL_RESET   = 8'h00;
   // General configuration fields
   localparam int          CFG_CRC_BIT     = 7;
   localparam int          CFG_AUTOACK_BIT = 5;
   localparam int          CFG_FILTER_BIT  = 4;
   localparam int          CFG_PASS_BIT    = 3;
   localparam logic [7:0]  GEN_CFG_RESET   = 8'hd2;
   // Sync filter: least pulse width kept, in pixel clocks
   localparam int          FILT_MIN_CLKS   = 2;
   localparam int          NUM_SYNC        = 3;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } scgc_reg_req_t;

   typedef struct packed {
      logic             start;
      logic             is_read;
      logic [TGT_W-1:0] target;
   } scgc_loc_req_t;

   typedef struct packed {
      logic done;
      logic nack;
      logic err;
   } scgc_rem_rsp_t;

   typedef enum logic [0:0] {FWD_IDLE, FWD_WAIT} scgc_fwd_state_t;
endpackage : scgc_pkg

// ==== rtl/scgc_top.sv ====
// Purpose: Configuration bits, soft resets, sync filter and remote forwarding control
// Assumes: Pixel clock is core_clk; all inputs synchronous to it
// Notes:   Alias table lives outside and is presented as a flat input vector
`timescale 1ns/1ps
`default_nettype none
module scgc_top
   import scgc_pkg::*;
#(
   parameter int NUM_ALIAS = 8
) (
   input  wire logic                       core_clk,               // Pixel clock
   input  wire logic                       rstn,                   // Async reset, active low
   input  wire scgc_reg_req_t              reg_req,                // Register access request
   output logic [DATA_W-1:0]               reg_rdata_q,            // Read data
   output logic                            reg_rvalid_q,           // Read data valid pulse
   output logic                            crc_check_en_q,         // Back-channel CRC checker enable
   output logic                            remote_pwrdn_en_q,      // Remote auto power down enable
   output logic                            logic_reset_q,          // Reset pulse to the rest of the logic
   input  wire logic                       horizontal_sync_input,  // Raw horizontal sync
   input  wire logic                       vertical_sync_input,    // Raw vertical sync
   input  wire logic                       video_data_valid,       // Raw data enable
   output logic [NUM_SYNC-1:0]             sync_filt_q,            // Filtered {valid, vsync, hsync}
   input  wire logic [NUM_ALIAS*TGT_W-1:0] remote_target_alias,    // Alias table entries
   input  wire logic [TGT_W-1:0]           remote_deser_id,        // Remote deserializer address
   input  wire logic                       pass_all_en,            // Forward any remote target
   input  wire scgc_loc_req_t              loc_req,                // Local I2C transaction start
   output logic                            loc_ack_q,              // Acknowledge to local master
   output logic                            loc_nack_q,             // Refusal to local master
   output logic                            fwd_req_q,              // Forward request pulse to remote
   output logic                            fwd_is_read_q,          // Forwarded transaction is a read
   output logic [TGT_W-1:0]                fwd_target_q,           // Forwarded target address
   input  wire scgc_rem_rsp_t              rem_rsp                 // Remote completion
);
   // Alias table needs at least one entry to compare against
   if (NUM_ALIAS < 1) begin : g_bad_alias
      $error("NUM_ALIAS must be at least one");
   end

   // Register group
   logic [DATA_W-1:0] gen_cfg_q, gen_cfg_d;
   logic              pwrdn_d, rdv_d, keep_q, keep_d, full_q, full_d;
   logic [DATA_W-1:0] rdata_d;
   logic              wr_rst, wr_cfg;

   always_comb begin
      wr_rst    = reg_req.wr && reg_req.addr == OFS_SOFT_RESET;
      wr_cfg    = reg_req.wr && reg_req.addr == OFS_GEN_CFG;
      gen_cfg_d = gen_cfg_q;
      pwrdn_d   = remote_pwrdn_en_q;
      keep_d    = wr_rst && reg_req.wdata[RST_KEEP_BIT];
      full_d    = wr_rst && reg_req.wdata[RST_FULL_BIT];
      if (full_q) begin
         gen_cfg_d = GEN_CFG_RESET;
         pwrdn_d   = RST_CTL_RESET[RST_PWRDN_BIT];
      end else begin
         if (wr_cfg) gen_cfg_d = reg_req.wdata;
         if (wr_rst) pwrdn_d = reg_req.wdata[RST_PWRDN_BIT];
      end
      rdv_d   = reg_req.rd;
      rdata_d = '0;
      // Reset bits are pulses, so they always read back as zero
      if (reg_req.addr == OFS_SOFT_RESET) rdata_d[RST_PWRDN_BIT] = remote_pwrdn_en_q;
      else if (reg_req.addr == OFS_GEN_CFG) rdata_d = gen_cfg_q;
      if (!reg_req.rd) rdata_d = reg_rdata_q;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gen_cfg_q         <= GEN_CFG_RESET;
         remote_pwrdn_en_q <= 1'b0;
         keep_q            <= 1'b0;
         full_q            <= 1'b0;
         reg_rvalid_q      <= 1'b0;
         reg_rdata_q       <= '0;
         crc_check_en_q    <= 1'b1;
         logic_reset_q     <= 1'b0;
      end else begin
         gen_cfg_q         <= gen_cfg_d;
         remote_pwrdn_en_q <= pwrdn_d;
         keep_q            <= keep_d;
         full_q            <= full_d;
         reg_rvalid_q      <= rdv_d;
         reg_rdata_q       <= rdata_d;
         crc_check_en_q    <= gen_cfg_d[CFG_CRC_BIT];
         logic_reset_q     <= keep_d | full_d;
      end
   end

   logic sreset;
   assign sreset = keep_q | full_q;

   // Sync filter: output follows only a level held two clocks
   logic [NUM_SYNC-1:0] sync_in, samp_q, samp_d, filt_d;
   assign sync_in = {video_data_valid, vertical_sync_input, horizontal_sync_input};

   for (genvar i = 0; i < NUM_SYNC; i++) begin : g_filt
      always_comb begin
         samp_d[i] = sync_in[i];
         filt_d[i] = sync_filt_q[i];
         if (sreset) begin
            samp_d[i] = 1'b0;
            filt_d[i] = 1'b0;
         end else if (!gen_cfg_q[CFG_FILTER_BIT]) begin
            filt_d[i] = sync_in[i];
         end else if (sync_in[i] == samp_q[i]) begin
            filt_d[i] = sync_in[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         samp_q      <= '0;
         sync_filt_q <= '0;
      end else begin
         samp_q      <= samp_d;
         sync_filt_q <= filt_d;
      end
   end

   // Forwarding of local transactions to the remote end
   logic [NUM_ALIAS-1:0] alias_hit;
   for (genvar a = 0; a < NUM_ALIAS; a++) begin : g_alias
      assign alias_hit[a] = remote_target_alias[a*TGT_W +: TGT_W] == loc_req.target;
   end

   scgc_fwd_state_t  st_q, st_d;
   logic             masked_q, masked_d, ack_d, nack_d, fwd_d, frd_d;
   logic [TGT_W-1:0] ftgt_d;
   logic             remote_hit, auto_ack;

   always_comb begin
      remote_hit = loc_req.target == remote_deser_id || pass_all_en
                   || (gen_cfg_q[CFG_PASS_BIT] && |alias_hit);
      // Alias-only targets keep the normal ack unless forward-all is on
      auto_ack   = gen_cfg_q[CFG_AUTOACK_BIT] && !loc_req.is_read
                   && (loc_req.target == remote_deser_id || pass_all_en);
      st_d     = st_q;
      masked_d = masked_q;
      ack_d    = 1'b0;
      nack_d   = 1'b0;
      fwd_d    = 1'b0;
      frd_d    = fwd_is_read_q;
      ftgt_d   = fwd_target_q;
      case (st_q)
         FWD_IDLE: begin
            if (loc_req.start && remote_hit) begin
               fwd_d    = 1'b1;
               frd_d    = loc_req.is_read;
               ftgt_d   = loc_req.target;
               ack_d    = auto_ack;
               masked_d = auto_ack;
               st_d     = FWD_WAIT;
            end
         end
         FWD_WAIT: begin
            if (rem_rsp.done) begin
               // After an early ack, remote failures are swallowed; otherwise they give a nack
               ack_d  = !masked_q && !rem_rsp.nack && !rem_rsp.err;
               nack_d = !masked_q && (rem_rsp.nack || rem_rsp.err);
               masked_d = 1'b0;
               st_d   = FWD_IDLE;
            end
         end
         default: st_d = FWD_IDLE;
      endcase
      if (sreset) begin
         st_d     = FWD_IDLE;
         masked_d = 1'b0;
         ack_d    = 1'b0;
         nack_d   = 1'b0;
         fwd_d    = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q          <= FWD_IDLE;
         masked_q      <= 1'b0;
         loc_ack_q     <= 1'b0;
         loc_nack_q    <= 1'b0;
         fwd_req_q     <= 1'b0;
         fwd_is_read_q <= 1'b0;
         fwd_target_q  <= '0;
      end else begin
         st_q          <= st_d;
         masked_q      <= masked_d;
         loc_ack_q     <= ack_d;
         loc_nack_q    <= nack_d;
         fwd_req_q     <= fwd_d;
         fwd_is_read_q <= frd_d;
         fwd_target_q  <= ftgt_d;
      end
   end

   property p_keep_reset;
      @(posedge core_clk) disable iff (!rstn)
      (wr_rst && reg_req.wdata[RST_KEEP_BIT] && !reg_req.wdata[RST_FULL_BIT] && !full_q && !wr_cfg)
      |=> logic_reset_q ##1 (!logic_reset_q || $past(wr_rst)) && ($stable(gen_cfg_q) || $past(wr_cfg));
   endproperty
   a_keep_reset: assert property (p_keep_reset) else $error("keep-config reset wrong");

   property p_crc_en;
      @(posedge core_clk) disable iff (!rstn)
      (wr_cfg && !full_q) |=> crc_check_en_q == $past(reg_req.wdata[CFG_CRC_BIT]);
   endproperty
   a_crc_en: assert property (p_crc_en) else $error("crc enable mismatch");

   property p_auto_ack;
      @(posedge core_clk) disable iff (!rstn)
      (st_q == FWD_IDLE && loc_req.start && !loc_req.is_read && gen_cfg_q[CFG_AUTOACK_BIT] && !sreset
       && (loc_req.target == remote_deser_id || pass_all_en)) |=> loc_ack_q && fwd_req_q;
   endproperty
   a_auto_ack: assert property (p_auto_ack) else $error("write not acked at once");

   property p_no_remote_nack;
      @(posedge core_clk) disable iff (!rstn)
      (st_q == FWD_WAIT && masked_q && rem_rsp.done) |=> !loc_nack_q && !loc_ack_q;
   endproperty
   a_no_remote_nack: assert property (p_no_remote_nack) else $error("remote nack leaked");

   property p_filter;
      @(posedge core_clk) disable iff (!rstn || sreset)
      ($past(gen_cfg_q[CFG_FILTER_BIT]) && $rose(sync_filt_q[0]))
      |-> $past(horizontal_sync_input, 1) && $past(horizontal_sync_input, 2);
   endproperty
   a_filter: assert property (p_filter) else $error("short hsync pulse passed");

   property p_pass;
      @(posedge core_clk) disable iff (!rstn)
      (st_q == FWD_IDLE && loc_req.start && gen_cfg_q[CFG_PASS_BIT] && |alias_hit && !sreset)
      |=> fwd_req_q && fwd_target_q == $past(loc_req.target);
   endproperty
   a_pass: assert property (p_pass) else $error("alias match not forwarded");

   property p_full_reset;
      @(posedge core_clk) disable iff (!rstn)
      (wr_rst && reg_req.wdata[RST_FULL_BIT]) |=> logic_reset_q ##1 gen_cfg_q == GEN_CFG_RESET;
   endproperty
   a_full_reset: assert property (p_full_reset) else $error("full reset kept config");

   property p_read_waits;
      @(posedge core_clk) disable iff (!rstn)
      (st_q == FWD_IDLE && loc_req.start && remote_hit && loc_req.is_read && !sreset)
      |=> !loc_ack_q ##0 (st_q == FWD_WAIT && !masked_q);
   endproperty
   a_read_waits: assert property (p_read_waits) else $error("read acked early");
endmodule : scgc_top
`default_nettype wire

// ==== verif/scgc_rem_model.sv ====
// Purpose: Remote end model answering forwarded transactions
// Assumes: One forward in flight at a time
// Notes:   Qualifiers churn outside done so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module scgc_rem_model
   import scgc_pkg::*;
(
   input  wire logic     core_clk,  // Pixel clock
   input  wire logic     rstn,      // Async reset, active low
   input  wire logic     fwd_req_q, // Forward request pulse
   input  wire logic [3:0] dly,     // Answer delay in clocks
   input  wire logic     rem_nack,  // Refuse the transaction
   output var scgc_rem_rsp_t rem_rsp // Completion
);
   logic [3:0] cnt_q;
   logic       tog_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q   <= 4'h0;
         tog_q   <= 1'b0;
         rem_rsp <= '0;
      end else begin
         tog_q   <= ~tog_q;
         cnt_q   <= fwd_req_q ? dly : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q);
         rem_rsp.done <= (cnt_q == 4'h1);
         rem_rsp.nack <= (cnt_q == 4'h1) ? rem_nack : tog_q;
         rem_rsp.err  <= (cnt_q == 4'h1) ? rem_nack : ~tog_q;
      end
   end
endmodule : scgc_rem_model
`default_nettype wire

// ==== verif/scgc_top_tb.sv ====
// Purpose: Self-checking bench of the configuration bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Reset, ack and nack pulses are counted by edge monitors
`timescale 1ns/1ps
`default_nettype none
module scgc_top_tb;
   import scgc_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, pall = 1'b0, rnack = 1'b0;
   scgc_reg_req_t rq = '0;
   scgc_loc_req_t lq = '0;
   scgc_rem_rsp_t rs;
   logic [2:0] sy = 3'h0, sf;
   logic [3:0] dl = 4'h2;
   logic [55:0] alias_v = {{4{7'h55}}, 7'h2a, {3{7'h55}}};
   logic [7:0] rdata;
   logic rvalid, crc, pwd, lrst, ack, nack, freq, frd;
   logic [6:0] ftgt;
   int num_errors = 0, n_tests = 0, cyc_n = 0, n_lrst = 0, n_ack = 0, n_nack = 0;
   always #2 core_clk = ~core_clk;
   scgc_top i_dut (.core_clk(core_clk), .rstn(rstn), .reg_req(rq), .reg_rdata_q(rdata),
      .reg_rvalid_q(rvalid), .crc_check_en_q(crc), .remote_pwrdn_en_q(pwd), .logic_reset_q(lrst),
      .horizontal_sync_input(sy[0]), .vertical_sync_input(sy[1]), .video_data_valid(sy[2]),
      .sync_filt_q(sf), .remote_target_alias(alias_v), .remote_deser_id(7'h60), .pass_all_en(pall),
      .loc_req(lq), .loc_ack_q(ack), .loc_nack_q(nack), .fwd_req_q(freq), .fwd_is_read_q(frd),
      .fwd_target_q(ftgt), .rem_rsp(rs));
   scgc_rem_model i_rem (.core_clk(core_clk), .rstn(rstn), .fwd_req_q(freq), .dly(dl),
      .rem_nack(rnack), .rem_rsp(rs));
   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   // Hang guard, well above the expected length
   always @(posedge core_clk) begin
      cyc_n++;
      n_lrst += lrst;
      n_ack += ack;
      n_nack += nack;
      if (cyc_n == 3000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(int n = 1);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   // Idle cycle after each access so the request never changes twice at once
   task automatic wr(logic [7:0] a, logic [7:0] d);
      rq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc();
      rq = '0;
      cyc();
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] exp);
      rq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      cyc();
      rq = '0;
      chk("rvalid", 8'h01, {7'h0, rvalid});
      chk("rdata", exp, rdata);
      cyc();
   endtask : rd
   task automatic filt(int w, logic [2:0] exp);
      logic [2:0] seen;
      seen = 3'h0;
      sy = 3'h7;
      repeat (w) begin
         cyc();
         seen |= sf;
      end
      sy = 3'h0;
      repeat (5) begin
         cyc();
         seen |= sf;
      end
      chk("sync_filt", {5'h0, exp}, {5'h0, seen});
   endtask : filt
   task automatic xact(logic r, logic [6:0] t, logic f, logic a0, int at, int nt);
      int a, n;
      a = n_ack;
      n = n_nack;
      lq = '{start: 1'b1, is_read: r, target: t};
      cyc();
      lq = '0;
      chk("fwd_req", {7'h0, f}, {7'h0, freq});
      chk("early_ack", {7'h0, a0}, {7'h0, ack});
      if (f) begin
         chk("fwd_rd", {7'h0, r}, {7'h0, frd});
         chk("fwd_tgt", {1'b0, t}, {1'b0, ftgt});
      end
      cyc(14);
      chk("acks", 8'(at), 8'(n_ack - a));
      chk("nacks", 8'(nt), 8'(n_nack - n));
   endtask : xact
   initial begin
      cyc(2);
      rstn = 1'b1;
      cyc();
      rd(OFS_GEN_CFG, GEN_CFG_RESET);
      chk("crc_en", 8'h01, {7'h0, crc});
      rd(OFS_SOFT_RESET, 8'h00);
      rd(8'h20, 8'h00);
      filt(1, 3'h0);
      filt(2, 3'h7);
      wr(OFS_GEN_CFG, 8'h42);
      chk("crc_en", 8'h00, {7'h0, crc});
      filt(1, 3'h7);
      $display("Test config and filter done");
      wr(OFS_GEN_CFG, 8'h20);
      rnack = 1'b1;
      xact(1'b0, 7'h60, 1'b1, 1'b1, 1, 0);
      dl = 4'h9;
      xact(1'b1, 7'h60, 1'b1, 1'b0, 0, 1);
      xact(1'b0, 7'h2a, 1'b0, 1'b0, 0, 0);
      wr(OFS_GEN_CFG, 8'h08);
      rnack = 1'b0;
      xact(1'b0, 7'h2a, 1'b1, 1'b0, 1, 0);
      xact(1'b1, 7'h33, 1'b0, 1'b0, 0, 0);
      wr(OFS_GEN_CFG, 8'h28);
      xact(1'b0, 7'h2a, 1'b1, 1'b0, 1, 0);
      pall = 1'b1;
      wr(OFS_GEN_CFG, 8'h20);
      xact(1'b0, 7'h33, 1'b1, 1'b1, 1, 0);
      $display("Test forwarding done");
      wr(OFS_SOFT_RESET, 8'h81);
      cyc(2);
      chk("logic_reset", 8'h01, 8'(n_lrst));
      chk("pwrdn", 8'h01, {7'h0, pwd});
      rd(OFS_SOFT_RESET, 8'h80);
      rd(OFS_GEN_CFG, 8'h20);
      wr(OFS_SOFT_RESET, 8'h02);
      cyc(2);
      chk("logic_reset", 8'h02, 8'(n_lrst));
      rd(OFS_SOFT_RESET, 8'h00);
      rd(OFS_GEN_CFG, GEN_CFG_RESET);
      chk("crc_en", 8'h01, {7'h0, crc});
      $display("Test soft resets done");
      stop_test();
   end
endmodule : scgc_top_tb
`default_nettype wire
